// File: hdl/tc_readout_regs.svh
// Frame layout, reset values and timing counts for the thermocouple readout
`ifndef TC_READOUT_REGS_SVH
`define TC_READOUT_REGS_SVH

`define FRAME_BITS 16
`define FRAME_SIGN_POS 15
`define FRAME_TEMP_HI 14
`define FRAME_TEMP_LO 3
`define FRAME_OPEN_POS 2
`define FRAME_ID_POS 1
`define FRAME_TRI_POS 0
`define TEMP_BITS 12
`define TEMP_RESET 12'h000
`define TEMP_ZERO_C 12'h000
`define TEMP_MAX_C 12'hFFF
`define TEMP_LSB_MILLI_C 250
// Arbitrary identification value
`define DEVICE_ID_BIT 1'b1
`define CONV_TIME_MS 220
`define REF_CLK_HZ 40000000
// Divide first: the plain product overflows a 32-bit int
`define CONV_CYCLES (`CONV_TIME_MS * (`REF_CLK_HZ / 1000))

`endif

// File: hdl/tc_readout_pkg.sv
// Types shared by the thermocouple readout files
package tc_readout_pkg;
	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_RUN = 2'b01,
		CONV_DONE = 2'b10
	} conv_state_t;
	typedef logic [11:0] temp_code_t;
endpackage

// File: hdl/level_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module level_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Level in and out
	input wire logic i_level,
	output logic o_level
);
	logic meta_q;
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			meta_q <= RESET_VAL;
			o_level <= RESET_VAL;
		end else begin
			meta_q <= i_level;
			o_level <= meta_q;
		end
	end
endmodule

// File: hdl/frame_shifter.sv
// Link-side shift register clocked by the serial clock
`timescale 1ns/10ps
`include "tc_readout_regs.svh"
module frame_shifter (
	// Link
	input wire logic i_sclk,
	input wire logic i_select_n,
	// Result word, held stable by the core while select is low
	input wire logic [`FRAME_BITS-1:0] i_frame,
	// Next bit for the pin register, and drive enable
	output logic o_sdo,
	output logic o_sdo_oe
);
	logic [3:0] pos_q;
	// Position counts down on each falling edge and holds at zero; select high restarts it
	always_ff @(negedge i_sclk or posedge i_select_n) begin
		if (i_select_n) begin
			pos_q <= 4'hF;
		end else if (pos_q != 4'h0) begin
			pos_q <= pos_q - 4'h1;
		end
	end
	// Bit the pin register takes at the coming fall; tristated in the last slot
	always_comb begin
		o_sdo = i_frame[pos_q - 4'h1];
		o_sdo_oe = !i_select_n && (pos_q != 4'h0);
	end
endmodule

// File: hdl/tc_readout.sv
// Thermocouple readout: conversion control, result latch and serial frame
// What this block does
// - Serial port answers the clock only while select is held low.
// - Select falling aborts a running conversion; old result stays available.
// - Select rising starts a fresh conversion.
// - Select falling enables output and shows the first bit before clocking.
// - Output advances after each falling clock edge; host samples there.
// - Frame bit fifteen is a dummy sign, always zero.
// - Bits fourteen to three carry the temperature code, MSB first.
// - Bit two is one when the thermocouple input is open.
// - Bit one carries a fixed device identification value.
// - Bit zero is left high impedance.
// - All-zero code means zero degrees.
// - All-one code means 1023.75 degrees.
// - Select rising disables the output driver.
// - One code step equals a quarter degree.
`timescale 1ns/10ps
`include "tc_readout_regs.svh"
module tc_readout #(
	parameter int CONV_CYCLES = `CONV_CYCLES
) (
	// Core clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Serial link from the host
	input wire logic i_sclk,
	input wire logic i_select_n,
	// Converter front end, quarter-degree code
	input wire logic [11:0] i_adc_code,
	input wire logic i_input_open,
	// Serial data pin
	output logic o_sdo,
	output logic o_sdo_oe,
	// Status
	output logic o_converting,
	output logic o_result_valid
);
	tc_readout_pkg::conv_state_t state_q;
	tc_readout_pkg::temp_code_t result_q;
	tc_readout_pkg::temp_code_t frame_temp_q;
	logic open_q;
	logic frame_open_q;
	logic sel_sync;
	logic sel_prev_q;
	logic [31:0] count_q;
	logic [`FRAME_BITS-1:0] frame;
	logic sdo_raw;
	logic sdo_oe_raw;
	logic sel_fall;
	logic sel_rise;

	level_sync #(
		.RESET_VAL(1'b1)
	) u_sel_sync (
		.i_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_level(i_select_n),
		.o_level(sel_sync)
	);

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			sel_prev_q <= 1'b1;
		end else begin
			sel_prev_q <= sel_sync;
		end
	end
	assign sel_fall = sel_prev_q && !sel_sync;
	assign sel_rise = !sel_prev_q && sel_sync;

	// Conversion timer; abort on select low, restart on release
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			state_q <= tc_readout_pkg::CONV_RUN;
			count_q <= 32'h0000_0000;
		end else begin
			case (state_q)
				tc_readout_pkg::CONV_IDLE: begin
					if (sel_rise) begin
						state_q <= tc_readout_pkg::CONV_RUN;
						count_q <= 32'h0000_0000;
					end
				end
				tc_readout_pkg::CONV_RUN: begin
					if (sel_fall || !sel_sync) begin
						state_q <= tc_readout_pkg::CONV_IDLE;
					end else if (count_q >= 32'(CONV_CYCLES - 1)) begin
						state_q <= tc_readout_pkg::CONV_DONE;
					end else begin
						count_q <= count_q + 32'h0000_0001;
					end
				end
				tc_readout_pkg::CONV_DONE: begin
					state_q <= tc_readout_pkg::CONV_IDLE;
				end
				default: begin
					state_q <= tc_readout_pkg::CONV_IDLE;
				end
			endcase
		end
	end

	// Result store: the code is passed straight through, 0.25 C per step
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			result_q <= `TEMP_RESET;
			open_q <= 1'b0;
			o_result_valid <= 1'b0;
		end else if (state_q == tc_readout_pkg::CONV_DONE) begin
			result_q <= i_adc_code;
			open_q <= i_input_open;
			o_result_valid <= 1'b1;
		end
	end

	// Frame is frozen while select is low so a read never tears
	// Last copy lands within two core cycles of select falling, before any sample
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			frame_temp_q <= `TEMP_RESET;
			frame_open_q <= 1'b0;
		end else if (sel_sync) begin
			frame_temp_q <= result_q;
			frame_open_q <= open_q;
		end
	end

	always_comb begin
		frame = '0;
		frame[`FRAME_SIGN_POS] = 1'b0;
		frame[`FRAME_TEMP_HI:`FRAME_TEMP_LO] = frame_temp_q;
		frame[`FRAME_OPEN_POS] = frame_open_q;
		frame[`FRAME_ID_POS] = `DEVICE_ID_BIT;
		frame[`FRAME_TRI_POS] = 1'b0;
	end

	// Link side runs on the host clock and select only
	frame_shifter u_shift (
		.i_sclk(i_sclk),
		.i_select_n(i_select_n),
		.i_frame(frame),
		.o_sdo(sdo_raw),
		.o_sdo_oe(sdo_oe_raw)
	);

	// Pin register on the link clock edge that moves the bit
	// Idle value is the constant sign bit, so bit fifteen stands before any clock
	always_ff @(negedge i_sclk or posedge i_select_n) begin
		if (i_select_n) begin
			o_sdo <= 1'b0;
		end else begin
			o_sdo <= sdo_raw;
		end
	end
	assign o_sdo_oe = sdo_oe_raw;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_converting <= 1'b0;
		end else begin
			o_converting <= (state_q == tc_readout_pkg::CONV_RUN);
		end
	end
endmodule

// File: sim/tc_readout_properties.sv
// Port checks for the thermocouple readout
`timescale 1ns/10ps
module tc_readout_props (
	// Watched ports
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_sclk,
	input wire logic i_select_n,
	input wire logic o_sdo,
	input wire logic o_sdo_oe,
	input wire logic o_converting,
	input wire logic o_result_valid
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	a_idle_off: assert property (i_select_n && $past(i_select_n) |-> !o_sdo_oe)
		else $error("driving while idle");
	a_fall_show: assert property ($fell(i_select_n) |-> o_sdo_oe && !o_sdo)
		else $error("no first bit");
	a_rise_off: assert property ($rose(i_select_n) |-> ##[0:3] !o_sdo_oe)
		else $error("driver kept on");
	a_abort_conv: assert property (!i_select_n [*5] |-> !o_converting)
		else $error("no abort");
	a_restart_conv: assert property ($rose(i_select_n) |-> ##[1:6] o_converting)
		else $error("no restart");
	a_done_valid: assert property ($fell(o_converting) && i_select_n |-> ##[0:2] o_result_valid)
		else $error("result not valid");
	a_valid_kept: assert property (o_result_valid |=> o_result_valid)
		else $error("result lost");
	a_shift_on_clock: assert property (!i_select_n && !$past(i_select_n) && $stable(i_sclk)
		|-> $stable(o_sdo) && $stable(o_sdo_oe))
		else $error("output moved without clock");
	c_read: cover property ($fell(i_select_n));
	c_done: cover property ($fell(o_converting));
	c_start: cover property ($rose(i_select_n));
endmodule

// File: sim/host_master.sv
// Host model reading frames over the serial link
`timescale 1ns/10ps
module host_master (
	// Link
	input wire logic i_sdo,
	input wire logic i_sdo_oe,
	output logic o_sclk,
	output logic o_select_n
);
	initial begin
		o_sclk = 1'b0;
		o_select_n = 1'b1;
	end
	// Clock idles low; bit taken just before each falling edge
	task automatic read_frame(output logic [15:0] d, output logic [15:0] oe);
		o_select_n = 1'b0;
		#100;
		for (int i = 15; i >= 0; i--) begin
			o_sclk = 1'b1;
			#80;
			// Released line reads as the inverse of the value held in the pin register
			d[i] = i_sdo_oe ? i_sdo : !i_sdo;
			oe[i] = i_sdo_oe;
			o_sclk = 1'b0;
			#80;
		end
		o_select_n = 1'b1;
	endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the thermocouple readout
`timescale 1ns/10ps
`include "tc_readout_regs.svh"
module tb_top;
	logic i_ref_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_sclk;
	logic i_select_n;
	logic [11:0] i_adc_code = 12'h000;
	logic i_input_open = 1'b0;
	logic o_sdo;
	logic o_sdo_oe;
	logic o_converting;
	logic o_result_valid;
	int err_total = 0;
	int comparisons = 0;
	// Abort flag, open flag, code
	logic [13:0] tv [5] = '{14'h0000, 14'h0FFF, 14'h1A5C, 14'h05A3, 14'h2000};
	logic [15:0] d;
	logic [15:0] oe;
	logic [15:0] last;
	tc_readout #(.CONV_CYCLES(20)) u_tc_readout (.i_ref_clk, .i_rst_b, .i_sclk, .i_select_n,
		.i_adc_code, .i_input_open, .o_sdo, .o_sdo_oe, .o_converting, .o_result_valid);
	host_master u_host_master (.i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe), .o_sclk(i_sclk),
		.o_select_n(i_select_n));
	initial begin
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end
	task automatic close_out();
		if (err_total == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] want);
		comparisons++;
		if (got !== want) begin
			err_total++;
			$display("mismatch t=%0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic wait_conv(input logic val);
		int n;
		n = 0;
		while (o_converting !== val && n < 200) begin
			@(negedge i_ref_clk);
			n++;
		end
		if (o_converting !== val) begin
			err_total++;
			$display("mismatch t=%0t conversion wait", $time);
			close_out();
		end
	endtask
	initial begin
		repeat (5) @(negedge i_ref_clk);
		i_rst_b = 1'b1;
		foreach (tv[k]) begin
			i_adc_code = tv[k][11:0];
			i_input_open = tv[k][12];
			wait_conv(1'b1);
			// An aborted conversion must leave the older frame in place
			if (tv[k][13] == 1'b0) begin
				wait_conv(1'b0);
				check({15'h0000, o_result_valid}, 16'h0001);
				last = {1'b0, tv[k][11:0], tv[k][12], `DEVICE_ID_BIT, 1'b0};
			end
			#7;
			u_host_master.read_frame(d, oe);
			check({d[15:1], 1'b0}, last);
			check(oe, 16'hFFFE);
			@(negedge i_ref_clk);
			check({15'h0000, o_sdo_oe}, 16'h0000);
		end
		close_out();
	end
endmodule
bind tc_readout tc_readout_props u_tc_readout_props (.i_ref_clk, .i_rst_b, .i_sclk,
	.i_select_n, .o_sdo, .o_sdo_oe, .o_converting, .o_result_valid);
